// >>> verilog/atd_defines.svh
// Offsets, field positions and reset values of the threshold comparator
`ifndef ATD_DEFINES_SVH
`define ATD_DEFINES_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define ATD_NCHAN 32
`define ATD_DW 16
// Implemented analog channels, one bit each
`define ATD_CHAN_IMPL 32'h00ffffff

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ATD_OFS_CTRL1 8'h00
`define ATD_OFS_CTRL5 8'h04
`define ATD_OFS_CTRL2 8'h08
`define ATD_OFS_HIT 8'h0c
`define ATD_OFS_STAT 8'h10
`define ATD_BUF_BIT 7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ATD_ON_BIT 7
`define ATD_CM_LSB 0
`define ATD_WM_LSB 2
`define ATD_ENA_BIT 7
`define ATD_IRQP_LSB 8
`define ATD_SMPI_LSB 2
`define ATD_IDX_BIT 15

// ----------------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------------
`define ATD_CM_RST 2'h0
`define ATD_WM_RST 2'h0
`define ATD_IRQP_RST 2'h0
`define ATD_SMPI_RST 5'h00
`define ATD_RESP_OKAY 2'h0
`define ATD_RESP_SLVERR 2'h2

`endif

// >>> verilog/atd_pkg.sv
// Types shared by the threshold comparator files
package atd_pkg;

    typedef enum logic [1:0] {
        CMP_LESS = 2'h0,
        CMP_GREATER = 2'h1,
        CMP_INSIDE = 2'h2,
        CMP_OUTSIDE = 2'h3
    } atd_cmp_t;

    typedef enum logic [1:0] {
        WR_LEGACY = 2'h0,
        WR_STORE = 2'h1,
        WR_DISCARD = 2'h2,
        WR_RSVD = 2'h3
    } atd_wpol_t;

    typedef enum logic [1:0] {
        IRQ_SCAN = 2'h0,
        IRQ_SCAN_MATCH = 2'h1,
        IRQ_MATCH = 2'h2,
        IRQ_NONE = 2'h3
    } atd_irqp_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [4:0] channel;
        logic [15:0] result;
    } atd_conv_t;

    typedef struct packed {
        logic module_on;
        logic enable;
        atd_cmp_t cmp;
        atd_wpol_t wpol;
        atd_irqp_t irqp;
        logic [4:0] smpi;
        logic indexed;
    } atd_cfg_t;

endpackage

// >>> verilog/atd_hit_cell.sv
// One sticky compare-hit flag
`timescale 1ns/10ps
module atd_hit_cell #(
    parameter bit IMPL = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic q_ff;
    logic nxt_q;

    always_comb begin
        nxt_q = q_ff;
        // Set beats a clear arriving in the same cycle
        if (set) begin
            nxt_q = 1'b1;
        end else if (clr) begin
            nxt_q = 1'b0;
        end
        if (!IMPL) begin
            nxt_q = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule

// >>> verilog/atd_top.sv
// Threshold-detect comparator with result buffer and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "atd_defines.svh"
module atd_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire atd_pkg::atd_conv_t conv,
    output logic module_on,
    output logic converter_irq_flag,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    import atd_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    atd_cfg_t cfg_ff, nxt_cfg;
    logic [`ATD_DW-1:0] buf_mem [0:`ATD_NCHAN-1];
    logic [31:0] hit_q, hit_set, hit_clr;
    logic match_scan_ff, nxt_match_scan, irq_ff, nxt_irq;
    logic [4:0] smp_cnt_ff, nxt_smp_cnt;

    logic aw_held_ff, nxt_aw_held;
    logic w_held_ff, nxt_w_held;
    logic [7:0] waddr_ff, nxt_waddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;

    logic bus_wr, wr_is_buf, conv_ok, do_cmp, scan_end, buf_we;
    logic hit, above, below;
    logic [4:0] lo_idx, hi_idx, buf_widx;
    logic [`ATD_DW-1:0] lo_thr, hi_thr, res, buf_wdata;

    // ------------------------------------------------------------------
    // Compare engine
    // ------------------------------------------------------------------
    always_comb begin
        res = conv.result;
        lo_idx = conv.channel;
        // Upper channels map onto themselves: no mirror protection
        hi_idx = {1'b1, conv.channel[3:0]};
        lo_thr = buf_mem[lo_idx];
        hi_thr = buf_mem[hi_idx];
        // Conversions only count while the converter is switched on
        conv_ok = conv.valid && cfg_ff.module_on;
        do_cmp = conv_ok && cfg_ff.enable && (cfg_ff.wpol != WR_LEGACY);
        scan_end = conv_ok && conv.last;
        above = 1'b0;
        below = 1'b0;
        hit = 1'b0;
        unique case (cfg_ff.cmp)
            CMP_GREATER: begin
                above = res > lo_thr;
                hit = above;
            end
            CMP_LESS: begin
                below = res < lo_thr;
                hit = below;
            end
            CMP_INSIDE: hit = (res > lo_thr) && (res < hi_thr);
            CMP_OUTSIDE: begin
                above = res > hi_thr;
                below = res < lo_thr;
                hit = above || below;
            end
        endcase
        hit = hit && do_cmp;

        hit_set = 32'h0;
        if (hit) begin
            hit_set[lo_idx] = 1'b1;
            if (cfg_ff.cmp == CMP_OUTSIDE && above) begin
                hit_set[hi_idx] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Buffer write selection
    // ------------------------------------------------------------------
    always_comb begin
        buf_we = 1'b0;
        buf_widx = lo_idx;
        buf_wdata = res;
        if (conv_ok && (!cfg_ff.enable || cfg_ff.wpol == WR_LEGACY)) begin
            buf_we = 1'b1;
        end else if (hit && cfg_ff.wpol == WR_STORE) begin
            buf_we = 1'b1;
            if (cfg_ff.cmp == CMP_OUTSIDE && above) begin
                buf_widx = hi_idx;
            end
        end else if (bus_wr && wr_is_buf && !cfg_ff.module_on) begin
            // Thresholds only while off, so no clash with conversions
            buf_we = 1'b1;
            buf_widx = waddr_ff[6:2];
            buf_wdata = wdata_ff[`ATD_DW-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (buf_we) begin
            buf_mem[buf_widx] <= buf_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Hit flags
    // ------------------------------------------------------------------
    always_comb begin
        hit_clr = 32'h0;
        if (bus_wr && waddr_ff == `ATD_OFS_HIT) begin
            for (int i = 0; i < 32; i++) begin
                hit_clr[i] = wstrb_ff[i/8] && !wdata_ff[i];
            end
        end
    end

    for (genvar g = 0; g < `ATD_NCHAN; g++) begin : g_hit
        atd_hit_cell #(
            .IMPL(1'((`ATD_CHAN_IMPL >> g) & 32'h1))
        ) u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(hit_set[g]),
            .clr(hit_clr[g]),
            .q(hit_q[g])
        );
    end

    // ------------------------------------------------------------------
    // Interrupt decision
    // ------------------------------------------------------------------
    always_comb begin
        nxt_irq = 1'b0;
        nxt_smp_cnt = smp_cnt_ff;
        nxt_match_scan = match_scan_ff || hit;
        if (scan_end) begin
            nxt_match_scan = 1'b0;
        end
        if (cfg_ff.enable) begin
            // Sample counter is held at zero while detect governs irqs
            nxt_smp_cnt = 5'h00;
            unique case (cfg_ff.irqp)
                IRQ_SCAN: nxt_irq = scan_end;
                IRQ_SCAN_MATCH: nxt_irq = scan_end && (match_scan_ff || hit);
                IRQ_MATCH: nxt_irq = hit;
                IRQ_NONE: nxt_irq = 1'b0;
            endcase
        end else if (conv_ok) begin
            if (smp_cnt_ff == cfg_ff.smpi) begin
                nxt_irq = 1'b1;
                nxt_smp_cnt = 5'h00;
            end else begin
                nxt_smp_cnt = smp_cnt_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
            smp_cnt_ff <= 5'h00;
            match_scan_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
            smp_cnt_ff <= nxt_smp_cnt;
            match_scan_ff <= nxt_match_scan;
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    assign bus_wr = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_is_buf = waddr_ff[`ATD_BUF_BIT];

    always_comb begin
        nxt_aw_held = aw_held_ff || (awvalid && awready_ff);
        nxt_w_held = w_held_ff || (wvalid && wready_ff);
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        if (awvalid && awready_ff) begin
            nxt_waddr = awaddr;
        end
        if (wvalid && wready_ff) begin
            nxt_wdata = wdata;
            nxt_wstrb = wstrb;
        end
        nxt_bvalid = bvalid_ff && !bready;
        nxt_bresp = bresp_ff;
        nxt_cfg = cfg_ff;
        if (bus_wr) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = `ATD_RESP_OKAY;
            if (!wr_is_buf) begin
                unique case (waddr_ff)
                    `ATD_OFS_CTRL1: begin
                        if (wstrb_ff[0]) begin
                            nxt_cfg.module_on = wdata_ff[`ATD_ON_BIT];
                        end
                    end
                    `ATD_OFS_CTRL5: begin
                        if (wstrb_ff[0]) begin
                            nxt_cfg.cmp = atd_cmp_t'(wdata_ff[`ATD_CM_LSB+:2]);
                            nxt_cfg.wpol = atd_wpol_t'(wdata_ff[`ATD_WM_LSB+:2]);
                            nxt_cfg.enable = wdata_ff[`ATD_ENA_BIT];
                        end
                        if (wstrb_ff[1]) begin
                            nxt_cfg.irqp = atd_irqp_t'(wdata_ff[`ATD_IRQP_LSB+:2]);
                        end
                    end
                    `ATD_OFS_CTRL2: begin
                        if (wstrb_ff[0]) begin
                            nxt_cfg.smpi = wdata_ff[`ATD_SMPI_LSB+:5];
                        end
                        if (wstrb_ff[1]) begin
                            nxt_cfg.indexed = wdata_ff[`ATD_IDX_BIT];
                        end
                    end
                    `ATD_OFS_HIT, `ATD_OFS_STAT: begin
                        nxt_bresp = `ATD_RESP_OKAY;
                    end
                    default: begin
                        nxt_bresp = `ATD_RESP_SLVERR;
                    end
                endcase
            end
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready = !nxt_w_held && !nxt_bvalid;
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rvalid = rvalid_ff && !rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = 32'h0;
            nxt_rresp = `ATD_RESP_OKAY;
            if (araddr[`ATD_BUF_BIT]) begin
                nxt_rdata[`ATD_DW-1:0] = buf_mem[araddr[6:2]];
            end else begin
                unique case (araddr)
                    `ATD_OFS_CTRL1: nxt_rdata[`ATD_ON_BIT] = cfg_ff.module_on;
                    `ATD_OFS_CTRL5: begin
                        nxt_rdata[`ATD_CM_LSB+:2] = cfg_ff.cmp;
                        nxt_rdata[`ATD_WM_LSB+:2] = cfg_ff.wpol;
                        nxt_rdata[`ATD_ENA_BIT] = cfg_ff.enable;
                        nxt_rdata[`ATD_IRQP_LSB+:2] = cfg_ff.irqp;
                    end
                    `ATD_OFS_CTRL2: begin
                        nxt_rdata[`ATD_SMPI_LSB+:5] = cfg_ff.smpi;
                        nxt_rdata[`ATD_IDX_BIT] = cfg_ff.indexed;
                    end
                    `ATD_OFS_HIT: nxt_rdata = hit_q;
                    `ATD_OFS_STAT: nxt_rdata[0] = match_scan_ff;
                    default: nxt_rresp = `ATD_RESP_SLVERR;
                endcase
            end
        end
        nxt_arready = !nxt_rvalid;
    end

    // ------------------------------------------------------------------
    // Register stage
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff <= '{module_on: 1'b0, enable: 1'b0,
                cmp: atd_cmp_t'(`ATD_CM_RST), wpol: atd_wpol_t'(`ATD_WM_RST),
                irqp: atd_irqp_t'(`ATD_IRQP_RST), smpi: `ATD_SMPI_RST,
                indexed: 1'b0};
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            waddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `ATD_RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `ATD_RESP_OKAY;
        end else begin
            cfg_ff <= nxt_cfg;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign module_on = cfg_ff.module_on;
    assign converter_irq_flag = irq_ff;
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
endmodule

// >>> testbench/atd_top_assertions.sv
// Port-level concurrent checks for the threshold comparator
`timescale 1ns/10ps
`include "atd_defines.svh"
module atd_top_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire atd_pkg::atd_conv_t conv,
    input wire logic module_on,
    input wire logic converter_irq_flag,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    import atd_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    a_reset_quiet:
    assert property ($rose(aresetn) |-> !awready && !wready && !arready
        && !bvalid && !rvalid && !converter_irq_flag)
        else $error("outputs not idle right after reset");
    a_write_answer:
    assert property (awvalid && awready && wvalid && wready
        |=> !bvalid && !awready ##1 bvalid)
        else $error("write response not two edges after handshake");
    a_read_answer:
    assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data not one edge after address");
    a_bresp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    a_rdata_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata)
        && $stable(rresp))
        else $error("read data changed before rready");
    a_b_release:
    assert property (bvalid && bready |=> !bvalid)
        else $error("write response not released after handshake");
    a_r_release:
    assert property (rvalid && rready |=> !rvalid)
        else $error("read data not released after handshake");
    a_busy_gates:
    assert property (bvalid || rvalid |-> !(bvalid && awready)
        && !(bvalid && wready) && !(rvalid && arready))
        else $error("ready raised while an answer is pending");
    a_rresp_legal:
    assert property (rvalid |-> rresp == `ATD_RESP_OKAY
        || rresp == `ATD_RESP_SLVERR && rdata == 32'h0)
        else $error("illegal read response");

    // ------------------------------------------------------------------
    // Conversion path
    // ------------------------------------------------------------------
    a_irq_cause:
    assert property (converter_irq_flag |-> $past(conv.valid)
        && $past(module_on))
        else $error("interrupt without a conversion the cycle before");
endmodule

bind atd_top atd_top_assertions atd_top_assertions_inst (
    .aclk(aclk), .aresetn(aresetn), .conv(conv), .module_on(module_on),
    .converter_irq_flag(converter_irq_flag), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
);

// >>> testbench/adc_threshold_detect_compare_test.sv
// Self-checking bench for the threshold comparator
`timescale 1ns/10ps
`include "atd_defines.svh"
module adc_threshold_detect_compare_test;
    import atd_pkg::*;
    localparam logic [1:0] OK = `ATD_RESP_OKAY;
    localparam logic [1:0] ERR = `ATD_RESP_SLVERR;
    localparam logic [7:0] A_C1 = `ATD_OFS_CTRL1;
    localparam logic [7:0] A_C5 = `ATD_OFS_CTRL5;
    localparam logic [7:0] A_HIT = `ATD_OFS_HIT;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    atd_conv_t conv = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic module_on, converter_irq_flag, awready, wready, bvalid;
    logic arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic iq[$];
    logic [15:0] m_buf[32];
    logic [15:0] lo, hi, res;
    int fails = 0, comparisons = 0, cycles = 0;
    int unsigned seed_v;

    atd_top atd_top_inst (
        .aclk(aclk), .aresetn(aresetn), .conv(conv), .module_on(module_on),
        .converter_irq_flag(converter_irq_flag), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp)
    );

    always #4 aclk = ~aclk;

    // ------------------------------------------------------------------
    // Scoreboard
    // ------------------------------------------------------------------
    task automatic tally(input logic ok, input string what);
        comparisons++;
        if (!ok) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_rd();
        logic [33:0] e = 'x;
        if (rq.size() != 0) e = rq.pop_front();
        tally(e === {rresp, rdata}, "read data or response");
    endtask
    task automatic cmp_b();
        logic [1:0] e = 'x;
        if (bq.size() != 0) e = bq.pop_front();
        tally(e === bresp, "write response");
    endtask
    task automatic cmp_irq();
        tally(iq.size() != 0, "unexpected interrupt");
        if (iq.size() != 0) iq.pop_front();
    endtask
    // Sampled mid-cycle, where registered outputs have settled
    always @(negedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) cmp_rd();
        if (bvalid === 1'b1 && bready === 1'b1) cmp_b();
        if (converter_irq_flag === 1'b1) cmp_irq();
    end
    task automatic wrap_up();
        tally(iq.size() == 0, "missing interrupt");
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            tally(1'b0, "timeout");
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic wait_hi(ref logic s);
        logic t = 1'b0;
        while (!t) begin
            @(negedge aclk);
            t = (s === 1'b1);
            @(posedge aclk);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] r);
        logic ta, tw;
        logic ga = 1'b0, gw = 1'b0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ga && gw)) begin
            @(negedge aclk);
            ta = (awready === 1'b1) && !ga;
            tw = (wready === 1'b1) && !gw;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            ga = ga || ta;
            gw = gw || tw;
        end
        wait_hi(bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] r);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hi(arready);
        arvalid <= 1'b0;
        wait_hi(rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic drive_conv(input logic [4:0] ch, input logic [15:0] v);
        conv <= '{valid: 1'b1, last: 1'b1, channel: ch, result: v};
        @(posedge aclk);
        conv <= '0;
        @(posedge aclk);
    endtask
    function automatic logic [7:0] buf_ad(input logic [4:0] n);
        return 8'h80 + {1'b0, n, 2'b00};
    endfunction

    // ------------------------------------------------------------------
    // One load-compare-inspect cycle
    // ------------------------------------------------------------------
    task automatic run_case(input logic [1:0] cm, wm, ip, input logic ena,
        input logic [4:0] ch, input logic [15:0] t1, t2, v);
        logic [4:0] mr;
        logic hit = 1'b0, up = 1'b0;
        logic [31:0] eh;
        mr = {1'b1, ch[3:0]};
        axi_write(A_C1, 32'h0, OK);
        tally(module_on === 1'b0, "module still switched on");
        axi_write(buf_ad(ch), {16'h0, t1}, OK);
        m_buf[ch] = t1;
        axi_write(buf_ad(mr), {16'h0, t2}, OK);
        m_buf[mr] = t2;
        axi_write(A_HIT, 32'h0, OK);
        axi_read(A_HIT, 32'h0, OK);
        axi_write(A_C5, {22'h0, ip, ena, 3'h0, wm, cm}, OK);
        // Converter still off: this one must leave no trace
        drive_conv(ch, v);
        axi_write(A_C1, 32'h80, OK);
        tally(module_on === 1'b1, "module not switched on");
        axi_write(buf_ad(ch), 32'h5a5a, OK);
        case (cm)
            CMP_LESS: hit = v < m_buf[ch];
            CMP_GREATER: hit = v > m_buf[ch];
            CMP_INSIDE: hit = v > m_buf[ch] && v < m_buf[mr];
            default: begin
                up = v > m_buf[mr];
                hit = up || v < m_buf[ch];
            end
        endcase
        if (!ena || wm == WR_LEGACY) begin
            hit = 1'b0;
            up = 1'b0;
            m_buf[ch] = v;
        end else if (hit && wm == WR_STORE) begin
            m_buf[up ? mr : ch] = v;
        end
        eh = ((32'(hit) << ch) | (32'(up) << mr)) & `ATD_CHAN_IMPL;
        if (!ena || ip == IRQ_SCAN || (hit && ip != IRQ_NONE)) begin
            iq.push_back(1'b1);
        end
        drive_conv(ch, v);
        axi_write(A_HIT, 32'hffffffff, OK);
        axi_read(A_HIT, eh, OK);
        axi_read(buf_ad(ch), {16'h0, m_buf[ch]}, OK);
        axi_read(buf_ad(mr), {16'h0, m_buf[mr]}, OK);
    endtask

    initial begin
        seed_v = $urandom(32'hef7e);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_read(A_C5, 32'h0, OK);
        axi_read(8'h14, 32'h0, ERR);
        axi_write(8'h14, 32'h1, ERR);
        axi_write(`ATD_OFS_CTRL2, 32'h8000, OK);
        axi_read(`ATD_OFS_CTRL2, 32'h8000, OK);
        run_case(CMP_GREATER, WR_STORE, IRQ_MATCH, 1, 2, 'h100, 'h300, 'h180);
        run_case(CMP_LESS, WR_DISCARD, IRQ_SCAN, 1, 3, 'h100, 'h300, 'h80);
        run_case(CMP_INSIDE, WR_STORE, IRQ_SCAN_MATCH, 1, 2, 'h100, 'h300,
                 'h200);
        run_case(CMP_OUTSIDE, WR_STORE, IRQ_MATCH, 1, 2, 'h100, 'h300,
                 'h400);
        run_case(CMP_OUTSIDE, WR_STORE, IRQ_NONE, 1, 2, 'h100, 'h300, 'h50);
        run_case(CMP_OUTSIDE, WR_DISCARD, IRQ_MATCH, 1, 9, 'h100, 'h300,
                 'h400);
        run_case(CMP_OUTSIDE, WR_STORE, IRQ_MATCH, 1, 20, 'h100, 'h300,
                 'h400);
        run_case(CMP_GREATER, WR_STORE, IRQ_MATCH, 1, 5, 'h100, 'h300, 'h100);
        run_case(CMP_INSIDE, WR_STORE, IRQ_MATCH, 1, 6, 'h100, 'h300, 'h300);
        run_case(CMP_GREATER, WR_STORE, IRQ_NONE, 0, 4, 'h100, 'h300,
                 'h200);
        run_case(CMP_GREATER, WR_LEGACY, IRQ_MATCH, 1, 7, 'h100, 'h300,
                 'h200);
        for (int i = 0; i < 14; i++) begin
            lo = 16'($urandom_range(1, 16'h7ffe));
            hi = lo + 16'($urandom_range(1, 16'h7fff));
            case ($urandom_range(0, 3))
                0: res = lo - 16'h1;
                1: res = lo + 16'h1;
                2: res = hi + 16'h1;
                default: res = 16'($urandom);
            endcase
            run_case(2'($urandom), 2'($urandom), 2'($urandom), 1'b1,
                     5'($urandom_range(0, 15)), lo, hi, res);
        end
        repeat (4) @(posedge aclk);
        wrap_up();
    end
endmodule
